// file: design/lqta_pkg.sv
package lqta_pkg;
    // register location on the management port
    localparam logic [4:0] LINK_QUALITY_DATA_ADDR = 5'h1e;
    localparam logic [15:0] LINK_QUALITY_DATA_RESET = 16'h0000;
    // field positions inside link_quality_data
    localparam int SAMPLE_BIT = 13;
    localparam int WRITE_STROBE_BIT = 12;
    localparam int PARAM_SEL_MSB = 11;
    localparam int PARAM_SEL_LSB = 9;
    localparam int BOUND_SEL_BIT = 8;
    localparam int VALUE_MSB = 7;
    localparam int VALUE_LSB = 0;
    // sizes
    localparam int VALUE_W = 8;
    localparam int SEL_W = 3;
    localparam int IDX_W = 4;
    localparam int NUM_PARAM = 5;
    localparam int NUM_ENTRY = 10;
    localparam int NUM_WARN = 10;
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;
    // parameter selector codes
    localparam logic [2:0] SEL_EQUALIZER = 3'h0;
    localparam logic [2:0] SEL_GAIN = 3'h1;
    localparam logic [2:0] SEL_BASELINE = 3'h2;
    localparam logic [2:0] SEL_FREQ_OFFSET = 3'h3;
    localparam logic [2:0] SEL_FREQ_CONTROL = 3'h4;
    // bound selector codes
    localparam logic BOUND_LOW = 1'b0;
    localparam logic BOUND_HIGH = 1'b1;
endpackage

// file: design/lqta_top.sv
// Operation
// - bits 15:14 ignore writes, read zero
// - sample bit captures selected live parameter value
// - write strobe stores data into addressed threshold
// - write strobe self-clears, always reads zero
// - selector codes pick one of five parameters
// - one selector serves sampling and threshold access
// - bound bit picks low or high threshold
// - sampling off: written data becomes threshold
// - sampling off: read returns addressed threshold
// - sampling on: read returns frozen captured value
// - no threshold updates while powered down
// - threshold crossing sets warning, optional interrupt
// - monitor runs only enabled with 100 Mb link
`timescale 1ns/10ps
`default_nettype none
module lqta_top (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [7:0] equalizer_first_coefficient_i,
    input wire logic [7:0] gain_control_value_i,
    input wire logic [7:0] baseline_wander_value_i,
    input wire logic [7:0] freq_offset_value_i,
    input wire logic [7:0] freq_control_value_i,
    input wire logic power_down_i,
    input wire logic link_100_valid_i,
    input wire logic monitor_enable_i,
    input wire logic interrupt_enable_i,
    input wire logic warn_clear_i,
    output logic [9:0] warning_o,
    output logic interrupt_o
);

    // entry index from parameter and bound selectors
    function automatic logic [lqta_pkg::IDX_W-1:0] entry_index(
        input logic [lqta_pkg::SEL_W-1:0] sel,
        input logic bound
    );
        entry_index = {sel, bound};
    endfunction

    // selector addresses an existing parameter
    function automatic logic sel_valid(input logic [lqta_pkg::SEL_W-1:0] sel);
        sel_valid = (sel <= lqta_pkg::SEL_FREQ_CONTROL);
    endfunction

    // register fields
    logic sample_en;
    logic [2:0] param_sel;
    logic bound_sel;
    logic [7:0] sampled_value;
    logic [7:0] threshold [0:lqta_pkg::NUM_ENTRY-1];
    logic [9:0] warn;

    // live parameter values by selector code
    logic [7:0] live [0:lqta_pkg::NUM_PARAM-1];
    assign live[lqta_pkg::SEL_EQUALIZER] = equalizer_first_coefficient_i;
    assign live[lqta_pkg::SEL_GAIN] = gain_control_value_i;
    assign live[lqta_pkg::SEL_BASELINE] = baseline_wander_value_i;
    assign live[lqta_pkg::SEL_FREQ_OFFSET] = freq_offset_value_i;
    assign live[lqta_pkg::SEL_FREQ_CONTROL] = freq_control_value_i;

    // write decode, fields of the incoming word
    wire hit = (reg_addr_i == lqta_pkg::LINK_QUALITY_DATA_ADDR);
    wire wr_hit = reg_wr_i && hit;
    wire rd_hit = reg_rd_i && hit;
    wire w_sample = reg_wdata_i[lqta_pkg::SAMPLE_BIT];
    wire w_strobe = reg_wdata_i[lqta_pkg::WRITE_STROBE_BIT];
    wire [2:0] w_sel = reg_wdata_i[lqta_pkg::PARAM_SEL_MSB:lqta_pkg::PARAM_SEL_LSB];
    wire w_bound = reg_wdata_i[lqta_pkg::BOUND_SEL_BIT];
    wire [7:0] w_value = reg_wdata_i[lqta_pkg::VALUE_MSB:lqta_pkg::VALUE_LSB];
    wire [3:0] w_idx = entry_index(w_sel, w_bound);
    wire [3:0] r_idx = entry_index(param_sel, bound_sel);

    // threshold store only with sampling off, valid selector and powered up
    wire thr_write = wr_hit && w_strobe && !w_sample && sel_valid(w_sel)
                     && !power_down_i;
    // capture on every write that asks for a sample
    wire capture = wr_hit && w_sample;
    wire [7:0] capture_value = sel_valid(w_sel) ? live[w_sel] : 8'h00;

    // read data of the addressed threshold entry
    wire [7:0] thr_read = sel_valid(param_sel) ? threshold[r_idx] : 8'h00;
    wire [7:0] read_value = sample_en ? sampled_value : thr_read;
    wire [15:0] read_word = {2'h0,
                             sample_en,
                             1'b0,
                             param_sel,
                             bound_sel,
                             read_value};

    // control fields; reserved bits and the strobe are never stored
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_en <= lqta_pkg::LINK_QUALITY_DATA_RESET[lqta_pkg::SAMPLE_BIT];
            param_sel <= lqta_pkg::LINK_QUALITY_DATA_RESET[lqta_pkg::PARAM_SEL_MSB:
                                                          lqta_pkg::PARAM_SEL_LSB];
            bound_sel <= lqta_pkg::LINK_QUALITY_DATA_RESET[lqta_pkg::BOUND_SEL_BIT];
        end else if (wr_hit) begin
            sample_en <= w_sample;
            param_sel <= w_sel;
            bound_sel <= w_bound;
        end
    end

    // captured value stays frozen until the next sample request
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sampled_value <= lqta_pkg::THRESHOLD_RESET;
        end else if (capture) begin
            sampled_value <= capture_value;
        end
    end

    // ten threshold entries
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < lqta_pkg::NUM_ENTRY; i++) begin
                threshold[i] <= lqta_pkg::THRESHOLD_RESET;
            end
        end else if (thr_write) begin
            threshold[w_idx] <= w_value;
        end
    end

    // read port: one cycle answer, unmapped address reads zero
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= lqta_pkg::LINK_QUALITY_DATA_RESET;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= rd_hit ? read_word : 16'h0000;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // monitoring qualified by enable and a valid 100 Mb link
    wire monitor_active = monitor_enable_i && link_100_valid_i;

    // compare each live value against its low and high entries
    logic [9:0] crossing;
    always_comb begin
        crossing = 10'h000;
        for (int p = 0; p < lqta_pkg::NUM_PARAM; p++) begin
            crossing[2 * p] = live[p] < threshold[2 * p];
            crossing[2 * p + 1] = live[p] > threshold[2 * p + 1];
        end
    end
    wire [9:0] warn_set = monitor_active ? crossing : 10'h000;

    // sticky warnings, a new crossing beats a clear in the same cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            warn <= 10'h000;
        end else begin
            warn <= warn_set | (warn_clear_i ? 10'h000 : warn);
        end
    end
    assign warning_o = warn;

    // interrupt while any warning stands and interrupts are enabled
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            interrupt_o <= 1'b0;
        end else begin
            interrupt_o <= interrupt_enable_i && (|(warn_set | (warn_clear_i ? 10'h000 : warn)));
        end
    end

endmodule
`default_nettype wire

// file: verification/lqta_sva.sv
`timescale 1ns/10ps
`default_nettype none
module lqta_sva (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // answer timing and read field checks
    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no answer");
    chk_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray");
    chk_write_silent: assert property (reg_wr_i && !reg_rd_i |=> !reg_rvalid_o)
        else $error("answer to write");
    chk_idle_zero: assert property (!reg_rvalid_o |-> !reg_rdata_o) else $error("idle data");
    chk_reserved_zero: assert property (reg_rvalid_o |-> !reg_rdata_o[15:14])
        else $error("reserved set");
    chk_strobe_zero: assert property (reg_rvalid_o |-> !reg_rdata_o[12])
        else $error("strobe set");
    chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i != 5'h1e |=> !reg_rdata_o)
        else $error("unmapped data");
    chk_select_echo: assert property ((reg_wr_i && reg_addr_i == 5'h1e) ##1
        (reg_rd_i && !reg_wr_i && reg_addr_i == 5'h1e) |=> reg_rdata_o[13:8] ==
        {$past(reg_wdata_i[13], 2), 1'b0, $past(reg_wdata_i[11:8], 2)}) else $error("echo");
endmodule
bind lqta_top lqta_sva i_sva (.clock_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o);
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, rd = 1'b0, pd = 1'b0;
    logic [4:0] ad = 5'h00, md = 5'h00; // md: sample, selector, bound
    logic [15:0] wd = 16'h0000, rdata;
    logic [3:0] mi = 4'h0;
    logic [7:0] cap = 8'h00, lv [5] = '{default: 8'h00}, thr [10] = '{default: 8'h00};
    int err_total = 0, samples_checked = 0;
    logic rv, io, ei = 1'b0;
    logic [9:0] wo, ew = 10'h000;
    always #20 clock_i = ~clock_i;
    lqta_top i_dut (.clock_i, .nrst_i, .reg_addr_i(ad), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .power_down_i(pd),
        .equalizer_first_coefficient_i(lv[0]), .gain_control_value_i(lv[1]),
        .baseline_wander_value_i(lv[2]), .freq_offset_value_i(lv[3]),
        .freq_control_value_i(lv[4]), .monitor_enable_i(mi[0]), .link_100_valid_i(mi[1]),
        .interrupt_enable_i(mi[2]), .warn_clear_i(mi[3]), .warning_o(wo), .interrupt_o(io));
    // expected threshold crossings from the live values and the threshold image
    function automatic logic [9:0] exp_cross();
        logic [9:0] c = 10'h000;
        for (int p = 0; p < 5; p++) begin
            c[2 * p] = lv[p] < thr[2 * p];
            c[2 * p + 1] = lv[p] > thr[2 * p + 1];
        end
        return c;
    endfunction
    // one compare for every kind of result
    task automatic compare(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // expected answer from the register image
    function automatic logic [15:0] exp_w(input logic [4:0] ra);
        logic [7:0] v = (md[3:1] > 3'h4) ? 8'h00 : (md[4] ? cap : thr[md[3:0]]);
        return (ra == 5'h1e) ? {2'h0, md[4], 1'b0, md[3:0], v} : 16'h0000;
    endfunction
    task automatic give_verdict();
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // optional write, then a read of ra, then compare
    task automatic op(input logic w, input logic [15:0] d, input logic [4:0] ra, input logic p);
        @(posedge clock_i);
        {wr, ad, wd, pd} <= {w, 5'h1e, d, p};
        mi <= 4'($urandom);
        foreach (lv[k]) lv[k] <= 8'($urandom);
        @(posedge clock_i);
        {wr, rd, ad} <= {1'b0, 1'b1, ra};
        if (w && d[13]) cap = (d[11:9] > 3'h4) ? 8'h00 : lv[d[11:9]];
        if (w && d[12] && !d[13] && !p && d[11:9] < 3'h5) thr[d[11:8]] = d[7:0];
        if (w) md = {d[13], d[11:8]};
        @(posedge clock_i);
        rd <= 1'b0;
        #1 compare("reg_rdata_o", exp_w(ra), rdata);
        compare("reg_rvalid_o", 16'h0001, {15'h0000, rv});
    endtask
    // warning model, compared between clock edges while inputs are settled
    always @(negedge clock_i) begin
        if (nrst_i) begin
            compare("warning_o", {6'h00, ew}, {6'h00, wo});
            compare("interrupt_o", {15'h0000, ei}, {15'h0000, io});
            ew = ((mi[0] && mi[1]) ? exp_cross() : 10'h000) | (mi[3] ? 10'h000 : ew);
            ei = mi[2] && (|ew);
        end
    end
    // reset, directed corners, then random traffic
    initial begin
        void'($urandom(51763));
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        op(1'b0, 16'h0000, 5'h1e, 1'b0);
        for (int i = 0; i < 16; i++) op(1'b1, 16'h105a + 16'(i * 257), 5'h1e, 1'b0);
        op(1'b1, 16'hd3ff, 5'h1e, 1'b1);
        for (int i = 0; i < 8; i++) begin
            op(1'b1, 16'h2000 + 16'(i * 512), 5'h1e, 1'b0);
            op(1'b0, 16'h0000, 5'h1e, 1'b0);
        end
        for (int i = 0; i < 300; i++) op(1'($urandom), 16'($urandom),
            $urandom_range(3) ? 5'h1e : 5'($urandom), $urandom_range(3) == 0);
        give_verdict();
    end
    // watchdog far beyond the roughly 1000 cycles of traffic
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
